// ### design/frtcc_timer.sv
// Compare, capture and control logic of a 16-bit free-running timer.
// Assumes the counter, its status flags and levels live outside and
// arrive here as plain inputs; all inputs except the asynchronous rst are synchronous to mclk.
// Notes on behaviour
// RULE1 - Both compares matched continuously, set flags
// RULE2 - Enabled match drives pin to chosen level
// RULE3 - Compare pins low until first match
// RULE4 - Compare registers all ones on reset/standby
// RULE5 - Selected edge captures counter, sets flag
// RULE6 - Edge select: zero falling, one rising
// RULE7 - Source holds capture pulse 1.5 cycles
// RULE8 - Capture register zero on reset/standby
// RULE9 - Capture overwrites even with flag set
// RULE10 - Control register read/write, zero on reset
// RULE11 - Bit 7 gates capture interrupt
// RULE12 - Bit 6 gates match B interrupt
// RULE13 - Bit 5 gates match A interrupt
// RULE14 - Bit 4 gates wrap interrupt
// RULE15 - Bits 3,2 enable compare pin outputs
// RULE16 - Bits 1:0 select counter clock source
// RULE17 - External clock counted on rising edges
// RULE18 - Upper write held, lower write commits
// RULE19 - Upper read latches lower into holding byte
`timescale 1ns/100ps
`default_nettype none
module frtcc_timer
	import frtcc_pkg::*;
#(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              standby,
	// CPU byte bus
	input  wire logic [15:0]       busAddr,
	input  wire logic              busWr,
	input  wire logic              busRd,
	input  wire logic [7:0]        busWrData,
	output logic      [7:0]        busRdData,
	// Counter and status register side
	input  wire logic [CNT_W-1:0]  runningCounter,
	input  wire logic              wrapFlag,
	input  wire logic              pinAMatchLevel,
	input  wire logic              pinBMatchLevel,
	input  wire logic              captureEdgeSelect,
	input  wire logic              matchAFlagClear,
	input  wire logic              matchBFlagClear,
	input  wire logic              captureFlagClear,
	output logic                   matchAFlag,
	output logic                   matchBFlag,
	output logic                   captureFlag,
	output logic                   countTick,
	output logic                   counterLoad,
	output logic      [CNT_W-1:0]  counterLoadValue,
	output logic      [1:0]        clockSelect,
	// Pins
	input  wire logic              captureInputPin,
	input  wire logic              extCountClockPin,
	output logic                   compareAPin,
	output logic                   compareBPin,
	// Interrupt requests
	output logic                   captureIrq,
	output logic                   matchBIrq,
	output logic                   matchAIrq,
	output logic                   wrapIrq
);

	initial begin
		if (CNT_W != 16)
			$error("frtcc_timer serves only a 16-bit counter");
	end

	typedef struct packed {
		logic [7:0]       ctrl;
		logic [15:0]      cmpA;
		logic [15:0]      cmpB;
		logic [15:0]      cap;
		logic [7:0]       hold;
		logic [7:0]       rdData;
		logic             flagA;
		logic             flagB;
		logic             flagCap;
		logic             pinA;
		logic             pinB;
		logic             capPrev;
		logic             extPrev;
		logic [4:0]       pre;
		logic             tick;
		logic             load;
		logic [15:0]      loadVal;
	} frtcc_state_s;

	localparam frtcc_state_s STATE_RST = '{
		ctrl: CTRL_RST, cmpA: CMP_RST, cmpB: CMP_RST, cap: CAP_RST,
		hold: 8'h00, rdData: 8'h00, flagA: 1'b0, flagB: 1'b0,
		flagCap: 1'b0, pinA: 1'b0, pinB: 1'b0, capPrev: 1'b0,
		extPrev: 1'b0, pre: 5'h00, tick: 1'b0, load: 1'b0,
		loadVal: 16'h0000};

	frtcc_state_s st_r;
	frtcc_state_s st_nxt;

	// Prescaler tap for the selected internal divider
	function automatic logic preTap(input logic [1:0] sel,
		input logic [4:0] pre);
		case (sel)
			CKS_DIV2:  preTap = (pre & PRE_MASK2) == PRE_MASK2;
			CKS_DIV8:  preTap = (pre & PRE_MASK8) == PRE_MASK8;
			CKS_DIV32: preTap = (pre & PRE_MASK32) == PRE_MASK32;
			default:   preTap = 1'b0;
		endcase
	endfunction : preTap

	logic matchA;
	logic matchB;
	logic capEdge;
	logic extRise;

	// RULE1 continuous compare
	assign matchA = runningCounter == st_r.cmpA;
	assign matchB = runningCounter == st_r.cmpB;
	// RULE6 edge select polarity
	assign capEdge = captureEdgeSelect ? (captureInputPin & ~st_r.capPrev)
		: (~captureInputPin & st_r.capPrev);
	// RULE17 external rising edge
	assign extRise = extCountClockPin & ~st_r.extPrev;

	always_comb begin
		st_nxt = st_r;
		st_nxt.capPrev = captureInputPin;
		st_nxt.extPrev = extCountClockPin;
		st_nxt.pre = st_r.pre + 5'h01;
		st_nxt.load = 1'b0;
		// RULE16 clock source select
		if (st_r.ctrl[BIT_CKS_HI:BIT_CKS_LO] == CKS_EXT)
			st_nxt.tick = extRise;
		else
			st_nxt.tick = preTap(st_r.ctrl[BIT_CKS_HI:BIT_CKS_LO], st_r.pre);

		// Set beats clear in the same cycle
		if (matchAFlagClear)
			st_nxt.flagA = 1'b0;
		if (matchBFlagClear)
			st_nxt.flagB = 1'b0;
		if (captureFlagClear)
			st_nxt.flagCap = 1'b0;
		// RULE1 set match flags
		if (matchA)
			st_nxt.flagA = 1'b1;
		if (matchB)
			st_nxt.flagB = 1'b1;
		// RULE2 RULE15 pin drive on match
		if (matchA && st_r.ctrl[BIT_PINA_OE])
			st_nxt.pinA = pinAMatchLevel;
		if (matchB && st_r.ctrl[BIT_PINB_OE])
			st_nxt.pinB = pinBMatchLevel;
		// RULE5 RULE9 capture regardless of flag
		if (capEdge) begin
			st_nxt.cap = runningCounter;
			st_nxt.flagCap = 1'b1;
		end

		// Bus reads answer one cycle later from a flop
		if (busRd) begin
			if (busAddr == ADDR_CTRL)
				st_nxt.rdData = st_r.ctrl;
			else if (busAddr == ADDR_CMPA_HI)
				st_nxt.rdData = st_r.cmpA[15:8];
			else if (busAddr == ADDR_CMPA_LO)
				st_nxt.rdData = st_r.cmpA[7:0];
			else if (busAddr == ADDR_CMPB_HI)
				st_nxt.rdData = st_r.cmpB[15:8];
			else if (busAddr == ADDR_CMPB_LO)
				st_nxt.rdData = st_r.cmpB[7:0];
			// RULE19 upper read latches lower
			else if (busAddr == ADDR_CAP_HI) begin
				st_nxt.rdData = st_r.cap[15:8];
				st_nxt.hold = st_r.cap[7:0];
			end else if (busAddr == ADDR_CNT_HI) begin
				st_nxt.rdData = runningCounter[15:8];
				st_nxt.hold = runningCounter[7:0];
			end else if (busAddr == ADDR_CAP_LO || busAddr == ADDR_CNT_LO)
				st_nxt.rdData = st_r.hold;
			else
				st_nxt.rdData = UNMAPPED_RD;
		end

		// Writes; the capture register ignores them
		if (busWr) begin
			// RULE10 control register write
			if (busAddr == ADDR_CTRL)
				st_nxt.ctrl = busWrData;
			// RULE18 upper write to holding byte
			else if (busAddr == ADDR_CMPA_HI || busAddr == ADDR_CMPB_HI
				|| busAddr == ADDR_CNT_HI)
				st_nxt.hold = busWrData;
			// RULE18 lower write commits word
			else if (busAddr == ADDR_CMPA_LO)
				st_nxt.cmpA = {st_r.hold, busWrData};
			else if (busAddr == ADDR_CMPB_LO)
				st_nxt.cmpB = {st_r.hold, busWrData};
			else if (busAddr == ADDR_CNT_LO) begin
				st_nxt.load = 1'b1;
				st_nxt.loadVal = {st_r.hold, busWrData};
			end
		end

		// RULE4 RULE8 RULE10 standby initialisation
		if (standby) begin
			st_nxt.ctrl = CTRL_RST;
			st_nxt.cmpA = CMP_RST;
			st_nxt.cmpB = CMP_RST;
			st_nxt.cap = CAP_RST;
		end
	end

	// RULE3 pins start low from reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			st_r <= STATE_RST;
		else
			st_r <= st_nxt;
	end

	assign busRdData = st_r.rdData;
	assign matchAFlag = st_r.flagA;
	assign matchBFlag = st_r.flagB;
	assign captureFlag = st_r.flagCap;
	assign countTick = st_r.tick;
	assign counterLoad = st_r.load;
	assign counterLoadValue = st_r.loadVal;
	assign clockSelect = st_r.ctrl[BIT_CKS_HI:BIT_CKS_LO];
	assign compareAPin = st_r.pinA;
	assign compareBPin = st_r.pinB;
	// RULE11 capture interrupt gate
	assign captureIrq = st_r.flagCap & st_r.ctrl[BIT_CAP_IE];
	// RULE12 match B interrupt gate
	assign matchBIrq = st_r.flagB & st_r.ctrl[BIT_MB_IE];
	// RULE13 match A interrupt gate
	assign matchAIrq = st_r.flagA & st_r.ctrl[BIT_MA_IE];
	// RULE14 wrap interrupt gate
	assign wrapIrq = wrapFlag & st_r.ctrl[BIT_WRAP_IE];

	// Checks
	sequence matchAEvt;
		!standby && runningCounter == st_r.cmpA;
	endsequence
	sequence capRise;
		!captureInputPin ##1 captureInputPin && captureEdgeSelect;
	endsequence
	sequence cmpAHiWrite;
		busWr && busAddr == ADDR_CMPA_HI;
	endsequence
	sequence cmpALoWrite;
		busWr && busAddr == ADDR_CMPA_LO && !standby;
	endsequence
	sequence capHiRead;
		busRd && busAddr == ADDR_CAP_HI && !capEdge;
	endsequence
	sequence capLoRead;
		busRd && busAddr == ADDR_CAP_LO && !(busWr && busAddr[15:8]
			== ADDR_CAP_HI[15:8]);
	endsequence
	sequence ctrlWrite;
		busWr && busAddr == ADDR_CTRL && !standby;
	endsequence
	sequence ctrlRead;
		busRd && busAddr == ADDR_CTRL && !busWr;
	endsequence

	match_flag_a: assert property (@(posedge mclk) disable iff (rst) // RULE1
		matchAEvt |=> matchAFlag)
		else $error("match A did not set its flag");
	pin_drive_a: assert property (@(posedge mclk) disable iff (rst) // RULE2
		matchAEvt ##0 (st_r.ctrl[BIT_PINA_OE] && !standby)
		|=> compareAPin == $past(pinAMatchLevel))
		else $error("compare A pin not at chosen level");
	pin_hold_a: assert property (@(posedge mclk) disable iff (rst) // RULE15
		!(matchA && st_r.ctrl[BIT_PINA_OE]) |=> $stable(compareAPin))
		else $error("compare A pin moved without enabled match");
	pin_low_a: assert property (@(posedge mclk) disable iff (rst) // RULE3
		!st_r.flagA && !$past(matchA) |-> !compareAPin || $past(compareAPin))
		else $error("compare A pin rose without a match");
	standby_init_a: assert property (@(posedge mclk) disable iff (rst) // RULE4
		standby |=> st_r.cmpA == CMP_RST && st_r.cmpB == CMP_RST
			&& st_r.cap == CAP_RST && st_r.ctrl == CTRL_RST)
		else $error("standby did not initialise registers");
	capture_take_a: assert property (@(posedge mclk) disable iff (rst) // RULE5
		capRise ##0 !standby |=> captureFlag
			&& st_r.cap == $past(runningCounter))
		else $error("rising capture edge not taken");
	capture_fall_a: assert property (@(posedge mclk) disable iff (rst) // RULE6
		!captureEdgeSelect && !st_r.capPrev && captureInputPin
			&& !captureFlagClear |=> captureFlag == $past(captureFlag))
		else $error("capture flag moved without selected edge");
	overwrite_cap_a: assert property (@(posedge mclk) disable iff (rst) // RULE9
		capEdge && captureFlag && !standby
		|=> st_r.cap == $past(runningCounter))
		else $error("capture not overwritten with flag set");
	ctrl_write_a: assert property (@(posedge mclk) disable iff (rst) // RULE10
		ctrlWrite ##1 !busWr && !standby ##1 ctrlRead
		|=> busRdData == $past(busWrData, 3))
		else $error("control register read back wrong");
	cap_irq_a: assert property (@(posedge mclk) disable iff (rst) // RULE11
		captureIrq == (captureFlag && st_r.ctrl[BIT_CAP_IE]))
		else $error("capture interrupt request wrong");
	irq_b_a: assert property (@(posedge mclk) disable iff (rst) // RULE12
		matchBFlag && st_r.ctrl[BIT_MB_IE] |-> matchBIrq)
		else $error("match B interrupt missing");
	irq_a_a: assert property (@(posedge mclk) disable iff (rst) // RULE13
		!st_r.ctrl[BIT_MA_IE] |-> !matchAIrq)
		else $error("match A interrupt while disabled");
	wrap_irq_a: assert property (@(posedge mclk) disable iff (rst) // RULE14
		wrapIrq |-> wrapFlag && st_r.ctrl[BIT_WRAP_IE])
		else $error("wrap interrupt without cause");
	// Tick must come from the divide-by-8 tap, not a source switch
	div_eight_a: assert property (@(posedge mclk) disable iff (rst) // RULE16
		clockSelect == CKS_DIV8 ##1 clockSelect == CKS_DIV8 && countTick
		|=> (!countTick || clockSelect != CKS_DIV8) [*7])
		else $error("divide by 8 ticks too close");
	ext_tick_a: assert property (@(posedge mclk) disable iff (rst) // RULE17
		clockSelect == CKS_EXT && !extCountClockPin ##1 extCountClockPin
			&& clockSelect == CKS_EXT
		|=> countTick)
		else $error("external rising edge not counted");
	word_commit_a: assert property (@(posedge mclk) disable iff (rst) // RULE18
		cmpAHiWrite ##1 cmpALoWrite
		|=> st_r.cmpA == {$past(busWrData, 2), $past(busWrData)})
		else $error("compare A word not committed");
	hold_read_a: assert property (@(posedge mclk) disable iff (rst) // RULE19
		capHiRead ##1 capLoRead ##0 !busWr
		|=> busRdData == $past(st_r.cap[7:0], 2))
		else $error("capture low byte not from holding byte");

endmodule : frtcc_timer
`default_nettype wire

// ### include/frtcc_pkg.sv
// Constants for the timer compare, capture and control block.
// Assumes an 8-bit CPU bus with a 16-bit byte address.
package frtcc_pkg;
	// Register byte addresses
	localparam logic [15:0] ADDR_CTRL    = 16'hff90;
	localparam logic [15:0] ADDR_CNT_HI  = 16'hff92;
	localparam logic [15:0] ADDR_CNT_LO  = 16'hff93;
	localparam logic [15:0] ADDR_CMPA_HI = 16'hff94;
	localparam logic [15:0] ADDR_CMPA_LO = 16'hff95;
	localparam logic [15:0] ADDR_CMPB_HI = 16'hff96;
	localparam logic [15:0] ADDR_CMPB_LO = 16'hff97;
	localparam logic [15:0] ADDR_CAP_HI  = 16'hff98;
	localparam logic [15:0] ADDR_CAP_LO  = 16'hff99;
	// Reset values and the unmapped read value
	localparam logic [7:0]  CTRL_RST     = 8'h00;
	localparam logic [15:0] CMP_RST      = 16'hffff;
	localparam logic [15:0] CAP_RST      = 16'h0000;
	localparam logic [7:0]  UNMAPPED_RD  = 8'h00;
	// Control field positions
	localparam int BIT_CAP_IE    = 7;
	localparam int BIT_MB_IE     = 6;
	localparam int BIT_MA_IE     = 5;
	localparam int BIT_WRAP_IE   = 4;
	localparam int BIT_PINB_OE   = 3;
	localparam int BIT_PINA_OE   = 2;
	localparam int BIT_CKS_HI    = 1;
	localparam int BIT_CKS_LO    = 0;
	// Clock source codes and prescaler tap masks
	localparam logic [1:0] CKS_DIV2  = 2'h0;
	localparam logic [1:0] CKS_DIV8  = 2'h1;
	localparam logic [1:0] CKS_DIV32 = 2'h2;
	localparam logic [1:0] CKS_EXT   = 2'h3;
	localparam logic [4:0] PRE_MASK2  = 5'h01;
	localparam logic [4:0] PRE_MASK8  = 5'h07;
	localparam logic [4:0] PRE_MASK32 = 5'h1f;
endpackage : frtcc_pkg

// ### verif/frtcc_counter_model.sv
// Behavioural free-running counter driven by the timer block.
// Assumes one clock mclk and an asynchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module frtcc_counter_model (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Timer side
	input  wire logic        countTick,
	input  wire logic        counterLoad,
	input  wire logic [15:0] counterLoadValue,
	output logic      [15:0] runningCounter
);
	// Load wins over a tick in the same cycle, as a CPU write would
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			runningCounter <= 16'h0000;
		else if (counterLoad)
			runningCounter <= counterLoadValue;
		else if (countTick)
			runningCounter <= runningCounter + 16'h0001;
	end
endmodule : frtcc_counter_model
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the timer compare, capture and control block.
// Assumes the counter model closes the tick/load loop; mclk is 25 MHz.
`timescale 1ns/100ps
`default_nettype none
module testbench
	import frtcc_pkg::*;
;
	logic        mclk = 1'b0;
	logic        rst, standby, busWr, busRd, wrapFlag;
	logic        pinAMatchLevel, pinBMatchLevel, captureEdgeSelect;
	logic        matchAFlagClear, matchBFlagClear, captureFlagClear;
	logic        captureInputPin, extCountClockPin;
	logic        matchAFlag, matchBFlag, captureFlag, countTick;
	logic        counterLoad, compareAPin, compareBPin;
	logic        captureIrq, matchBIrq, matchAIrq, wrapIrq;
	logic [15:0] busAddr, runningCounter, counterLoadValue;
	logic [7:0]  busWrData, busRdData, hi, lo;
	logic [1:0]  clockSelect;
	int          failures, compares, cycles, n;

	always #20 mclk = ~mclk;

	frtcc_timer #(.CNT_W(16)) i_frtcc_timer (.mclk, .rst, .standby,
		.busAddr, .busWr, .busRd, .busWrData, .busRdData,
		.runningCounter, .wrapFlag, .pinAMatchLevel, .pinBMatchLevel,
		.captureEdgeSelect, .matchAFlagClear, .matchBFlagClear,
		.captureFlagClear, .matchAFlag, .matchBFlag, .captureFlag,
		.countTick, .counterLoad, .counterLoadValue, .clockSelect,
		.captureInputPin, .extCountClockPin, .compareAPin, .compareBPin,
		.captureIrq, .matchBIrq, .matchAIrq, .wrapIrq);

	frtcc_counter_model i_frtcc_counter_model (.mclk, .rst, .countTick,
		.counterLoad, .counterLoadValue, .runningCounter);

	task automatic final_report();
		if (failures == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : cyc

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		busAddr   <= a;
		busWrData <= d;
		busWr     <= 1'b1;
		@(posedge mclk);
		busWr <= 1'b0;
	endtask : wr

	// Read data lands on the same edge that takes the strobe, from a flop
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge mclk);
		busAddr <= a;
		busRd   <= 1'b1;
		@(posedge mclk);
		busRd <= 1'b0;
		#1 d = busRdData;
	endtask : rd

	// Upper byte always first so the shared holding byte stays coherent;
	// both bytes on back-to-back cycles, as a word access would
	task automatic w16(input logic [15:0] a, input logic [15:0] v);
		@(posedge mclk);
		busAddr   <= a;
		busWrData <= v[15:8];
		busWr     <= 1'b1;
		@(posedge mclk);
		busAddr   <= a + 16'h0001;
		busWrData <= v[7:0];
		@(posedge mclk);
		busWr <= 1'b0;
	endtask : w16

	task automatic r16(input logic [15:0] a, input logic [15:0] exp);
		@(posedge mclk);
		busAddr <= a;
		busRd   <= 1'b1;
		@(posedge mclk);
		busAddr <= a + 16'h0001;
		#1 hi = busRdData;
		@(posedge mclk);
		busRd <= 1'b0;
		#1 lo = busRdData;
		chk({hi, lo}, exp);
	endtask : r16

	task automatic check_init();
		rd(ADDR_CTRL, lo);
		chk(16'(lo), 16'(CTRL_RST));
		r16(ADDR_CMPA_HI, CMP_RST);
		r16(ADDR_CMPB_HI, CMP_RST);
		r16(ADDR_CAP_HI, CAP_RST);
	endtask : check_init

	task automatic test_compare();
		chk(16'({compareAPin, compareBPin}), 16'h0000);
		@(posedge mclk);
		pinAMatchLevel <= 1'b1;
		pinBMatchLevel <= 1'b1;
		wr(ADDR_CTRL, 8'h64);
		w16(ADDR_CMPA_HI, 16'h0200);
		w16(ADDR_CMPB_HI, 16'h0204);
		r16(ADDR_CMPA_HI, 16'h0200);
		w16(ADDR_CNT_HI, 16'h01f0);
		for (n = 0; n < 200 && matchAFlag !== 1'b1; n++)
			cyc(1);
		chk(16'({matchAFlag, compareAPin, matchAIrq}), 16'h0007);
		chk(16'({matchBFlag, compareBPin}), 16'h0000);
		for (n = 0; n < 200 && matchBFlag !== 1'b1; n++)
			cyc(1);
		chk(16'({matchBFlag, compareBPin, matchBIrq}), 16'h0005);
		// Counter has moved past both matches, so the clears stick
		@(posedge mclk);
		matchAFlagClear <= 1'b1;
		matchBFlagClear <= 1'b1;
		@(posedge mclk);
		matchAFlagClear <= 1'b0;
		matchBFlagClear <= 1'b0;
		#1;
		chk(16'({matchAFlag, matchBFlag}), 16'h0000);
		chk(16'({matchAIrq, matchBIrq}), 16'h0000);
	endtask : test_compare

	task automatic test_capture();
		wr(ADDR_CTRL, 8'h83);
		w16(ADDR_CNT_HI, 16'h1234);
		@(posedge mclk);
		captureEdgeSelect <= 1'b1;
		captureInputPin   <= 1'b1;
		cyc(3);
		chk(16'({captureFlag, captureIrq}), 16'h0003);
		r16(ADDR_CAP_HI, 16'h1234);
		@(posedge mclk);
		extCountClockPin <= 1'b1;
		cyc(3);
		@(posedge mclk);
		extCountClockPin  <= 1'b0;
		captureEdgeSelect <= 1'b0;
		captureInputPin   <= 1'b0;
		cyc(3);
		r16(ADDR_CNT_HI, 16'h1235);
		r16(ADDR_CAP_HI, 16'h1235);
		wr(ADDR_CTRL, 8'h03);
		cyc(1);
		chk(16'({captureFlag, captureIrq}), 16'h0002);
		// rising edge ignored while falling selected
		@(posedge mclk);
		captureFlagClear <= 1'b1;
		@(posedge mclk);
		captureFlagClear <= 1'b0;
		captureInputPin  <= 1'b1;
		cyc(2);
		chk(16'(captureFlag), 16'h0000);
	endtask : test_capture

	task automatic test_wrap();
		@(posedge mclk);
		wrapFlag <= 1'b1;
		wr(ADDR_CTRL, 8'h10);
		cyc(1);
		chk(16'(wrapIrq), 16'h0001);
		wr(ADDR_CTRL, 8'h00);
		cyc(1);
		chk(16'(wrapIrq), 16'h0000);
	endtask : test_wrap

	task automatic test_clock();
		int exp [3] = '{32, 8, 2};
		int k;
		int t;
		for (k = 0; k < 3; k++) begin
			wr(ADDR_CTRL, 8'(k));
			cyc(1);
			t = 0;
			for (n = 0; n < 64; n++) begin
				if (countTick === 1'b1)
					t++;
				cyc(1);
			end
			chk(16'(t), 16'(exp[k]));
			chk(16'(clockSelect), 16'(k));
		end
	endtask : test_clock

	task automatic test_standby();
		wr(ADDR_CTRL, 8'ha5);
		rd(ADDR_CTRL, lo);
		chk(16'(lo), 16'h00a5);
		w16(ADDR_CAP_HI, 16'h5566);
		r16(ADDR_CAP_HI, 16'h1235);
		rd(16'hff9a, lo);
		chk(16'(lo), 16'(UNMAPPED_RD));
		@(posedge mclk);
		standby <= 1'b1;
		cyc(2);
		@(posedge mclk);
		standby <= 1'b0;
		check_init();
	endtask : test_standby

	// Ceiling well above the few hundred cycles the sequence needs
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			$display("MISMATCH %0t timeout", $time);
			final_report();
		end
	end

	initial begin
		{rst, standby, busWr, busRd, wrapFlag} = 5'h10;
		{pinAMatchLevel, pinBMatchLevel, captureEdgeSelect} = 3'h0;
		{matchAFlagClear, matchBFlagClear, captureFlagClear} = 3'h0;
		{captureInputPin, extCountClockPin} = 2'h0;
		busAddr   = 16'h0000;
		busWrData = 8'h00;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		check_init();
		test_compare();
		test_capture();
		test_wrap();
		test_clock();
		test_standby();
		final_report();
	end
endmodule : testbench
`default_nettype wire
